// ==== rtl/ssp_consts.svh ====
// Constants for the register space and data pointer bank
`ifndef SSP_CONSTS_SVH
`define SSP_CONSTS_SVH

// ----------------------------------------------------------------------
// Address space
// ----------------------------------------------------------------------
`define SSP_SPACE_BASE      8'h80
`define SSP_SPACE_BYTES     128
`define SSP_IRAM_BYTES      256
`define SSP_IRAM_BIT_BASE   4'h2
`define SSP_EXT_CAN_PAGE    8'hF7

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SSP_ADDR_SYS_CTRL   8'hB1
`define SSP_ADDR_STATUS_WORD 8'hD0
`define SSP_ADDR_DP_LO      8'h82
`define SSP_ADDR_DP_HI      8'h83
`define SSP_ADDR_PTR_SEL    8'h92
`define SSP_ADDR_PWR2       8'h88
`define SSP_ADDR_ANA_EN     8'h90
`define SSP_ADDR_VER_A      8'hFC
`define SSP_ADDR_VER_B      8'hFD
`define SSP_ADDR_VER_C      8'hFE

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define SSP_MAP_SEL_BIT     4
`define SSP_SYS_CTRL_WMASK  8'h3B
`define SSP_SYS_CTRL_RST    8'h21
`define SSP_STATUS_WORD_RST 8'h00
`define SSP_PWR2_RST        8'h00
`define SSP_ANA_EN_RST      8'hFF
`define SSP_PTR_SEL_W       3

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SSP_SYNC_STAGES     2

`endif

// ==== rtl/ssp_pkg.sv ====
// Types for the register space and data pointer bank
package ssp_pkg;

  // Register targets of one access, one-hot
  typedef enum logic [10:0] {
    SR_NONE        = 11'h001,
    SR_SYS_CTRL    = 11'h002,
    SR_STATUS_WORD = 11'h004,
    SR_DP_LO       = 11'h008,
    SR_DP_HI       = 11'h010,
    SR_PTR_SEL     = 11'h020,
    SR_PWR2        = 11'h040,
    SR_ANA_EN      = 11'h080,
    SR_VER_A       = 11'h100,
    SR_VER_B       = 11'h200,
    SR_VER_C       = 11'h400
  } ssp_reg_e;

  typedef logic [15:0] ssp_ptr_t;

endpackage : ssp_pkg

// ==== rtl/ssp_rst_sync.sv ====
// Two-stage synchroniser for the active-high external reset pin
`timescale 1ns/100ps
module ssp_rst_sync (
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic ce,
  input  wire logic rst_pin,
  output wire logic rst_sync
);

  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  always_comb begin
    meta_d = rst_pin;
    sync_d = meta_q;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else if (ce) begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign rst_sync = sync_q;

endmodule : ssp_rst_sync

// ==== rtl/ssp_top.sv ====
// Register space decoder with data pointer bank and reset synchroniser
`timescale 1ns/100ps
`include "ssp_consts.svh"
module ssp_top #(
  parameter int         NUM_PTRS = 8,
  parameter logic [7:0] VER_A_VAL = 8'h5A,
  parameter logic [7:0] VER_B_VAL = 8'h3C,
  parameter logic [7:0] VER_C_VAL = 8'h01
) (
  input  wire logic         clock,
  input  wire logic         resetn,
  input  wire logic         ce,
  input  wire logic         ext_reset,
  input  wire logic [7:0]   acc_addr,
  input  wire logic         acc_indirect,
  input  wire logic         acc_rd,
  input  wire logic         acc_wr,
  input  wire logic [7:0]   acc_wdata,
  input  wire logic [7:0]   bit_addr,
  input  wire logic         bit_rd,
  input  wire logic         bit_wr,
  input  wire logic         bit_wval,
  input  wire logic         dp_inc,
  input  wire logic         dp_load,
  input  wire logic [15:0]  dp_load_val,
  input  wire logic         ext_acc,
  output wire logic [7:0]   rdata,
  output wire logic         rvalid,
  output wire logic         hit,
  output wire logic         std_area,
  output wire logic         map_area,
  output wire logic         iram_sel,
  output wire logic         can_sel,
  output wire logic         ext_sel,
  output wire logic [15:0]  dptr,
  output wire logic         map_sel,
  output wire logic [7:0]   status_word,
  output wire logic [7:0]   pwr2,
  output wire logic [7:0]   ana_en,
  output wire logic         core_rst
);

  // ----------------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------------
  function automatic ssp_pkg::ssp_reg_e reg_dec(input logic [7:0] a,
                                                input logic       m);
    reg_dec = ssp_pkg::SR_NONE;
    if (a == `SSP_ADDR_SYS_CTRL) begin
      reg_dec = ssp_pkg::SR_SYS_CTRL;
    end else if (m) begin
      case (a)
        `SSP_ADDR_PWR2:   reg_dec = ssp_pkg::SR_PWR2;
        `SSP_ADDR_ANA_EN: reg_dec = ssp_pkg::SR_ANA_EN;
        `SSP_ADDR_VER_A:  reg_dec = ssp_pkg::SR_VER_A;
        `SSP_ADDR_VER_B:  reg_dec = ssp_pkg::SR_VER_B;
        `SSP_ADDR_VER_C:  reg_dec = ssp_pkg::SR_VER_C;
        default:          reg_dec = ssp_pkg::SR_NONE;
      endcase
    end else begin
      case (a)
        `SSP_ADDR_STATUS_WORD: reg_dec = ssp_pkg::SR_STATUS_WORD;
        `SSP_ADDR_DP_LO:       reg_dec = ssp_pkg::SR_DP_LO;
        `SSP_ADDR_DP_HI:       reg_dec = ssp_pkg::SR_DP_HI;
        `SSP_ADDR_PTR_SEL:     reg_dec = ssp_pkg::SR_PTR_SEL;
        default:               reg_dec = ssp_pkg::SR_NONE;
      endcase
    end
  endfunction : reg_dec

  logic                         rst_ext;
  logic [7:0]                   sys_ctrl_q,    sys_ctrl_d;
  logic [7:0]                   status_word_q, status_word_d;
  logic [`SSP_PTR_SEL_W-1:0]    ptr_sel_q,     ptr_sel_d;
  logic [7:0]                   pwr2_q,        pwr2_d;
  logic [7:0]                   ana_en_q,      ana_en_d;
  ssp_pkg::ssp_ptr_t            dp_q [NUM_PTRS];
  ssp_pkg::ssp_ptr_t            dp_d [NUM_PTRS];
  logic [7:0]                   rdata_q,    rdata_d;
  logic                         rvalid_q,   rvalid_d;
  logic                         hit_q,      hit_d;
  logic                         std_q,      std_d;
  logic                         map_q,      map_d;
  logic                         iram_q,     iram_d;
  logic                         can_q,      can_d;
  logic                         ext_q,      ext_d;
  logic [15:0]                  dptr_q,     dptr_d;
  logic                         rst_q;
  logic                         op_byte;
  logic                         op_bit;
  logic                         op_rd;
  logic                         op_wr;
  logic                         is_iram;
  logic [7:0]                   op_addr;
  logic [7:0]                   cur_val;
  logic [7:0]                   new_val;
  ssp_pkg::ssp_reg_e            sel;
  ssp_pkg::ssp_ptr_t            act_ptr;

  ssp_rst_sync ssp_rst_sync_inst (
    .clock    (clock),
    .resetn   (resetn),
    .ce       (ce),
    .rst_pin  (ext_reset),
    .rst_sync (rst_ext)
  );

  // ----------------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------------
  always_comb begin
    op_byte = acc_rd | acc_wr;
    op_bit  = !op_byte && (bit_rd | bit_wr);
    op_rd   = op_byte ? acc_rd : bit_rd;
    op_wr   = op_byte ? acc_wr : bit_wr;
    if (op_byte) begin
      op_addr = acc_addr;
    end else if (bit_addr[7]) begin
      op_addr = {bit_addr[7:3], 3'h0};
    end else begin
      op_addr = {`SSP_IRAM_BIT_BASE, bit_addr[6:3]};
    end
    is_iram = (op_byte && (acc_indirect || !acc_addr[7])) ||
              (op_bit && !bit_addr[7]);
    sel = is_iram ? ssp_pkg::SR_NONE :
                    reg_dec(op_addr, sys_ctrl_q[`SSP_MAP_SEL_BIT]);
    act_ptr = dp_q[ptr_sel_q];
    case (sel)
      ssp_pkg::SR_SYS_CTRL:    cur_val = sys_ctrl_q;
      ssp_pkg::SR_STATUS_WORD: cur_val = status_word_q;
      ssp_pkg::SR_DP_LO:       cur_val = act_ptr[7:0];
      ssp_pkg::SR_DP_HI:       cur_val = act_ptr[15:8];
      ssp_pkg::SR_PTR_SEL:     cur_val = {5'h00, ptr_sel_q};
      ssp_pkg::SR_PWR2:        cur_val = pwr2_q;
      ssp_pkg::SR_ANA_EN:      cur_val = ana_en_q;
      ssp_pkg::SR_VER_A:       cur_val = VER_A_VAL;
      ssp_pkg::SR_VER_B:       cur_val = VER_B_VAL;
      ssp_pkg::SR_VER_C:       cur_val = VER_C_VAL;
      default:                 cur_val = 8'h00;
    endcase
    new_val = cur_val;
    if (op_byte) begin
      new_val = acc_wdata;
    end else begin
      new_val[bit_addr[2:0]] = bit_wval;
    end
  end

  // ----------------------------------------------------------------------
  // Register and pointer bank
  // ----------------------------------------------------------------------
  always_comb begin
    sys_ctrl_d    = sys_ctrl_q;
    status_word_d = status_word_q;
    ptr_sel_d     = ptr_sel_q;
    pwr2_d        = pwr2_q;
    ana_en_d      = ana_en_q;
    for (int i = 0; i < NUM_PTRS; i++) begin
      dp_d[i] = dp_q[i];
    end
    if (op_wr) begin
      case (sel)
        ssp_pkg::SR_SYS_CTRL:
          sys_ctrl_d = (sys_ctrl_q & ~`SSP_SYS_CTRL_WMASK) |
                       (new_val & `SSP_SYS_CTRL_WMASK);
        ssp_pkg::SR_STATUS_WORD: status_word_d = new_val;
        ssp_pkg::SR_DP_LO:       dp_d[ptr_sel_q][7:0] = new_val;
        ssp_pkg::SR_DP_HI:       dp_d[ptr_sel_q][15:8] = new_val;
        ssp_pkg::SR_PTR_SEL:     ptr_sel_d = new_val[`SSP_PTR_SEL_W-1:0];
        ssp_pkg::SR_PWR2:        pwr2_d = new_val;
        ssp_pkg::SR_ANA_EN:      ana_en_d = new_val;
        default:                 sys_ctrl_d = sys_ctrl_q;
      endcase
    end
    if (dp_load) begin
      dp_d[ptr_sel_q] = dp_load_val;
    end else if (dp_inc) begin
      dp_d[ptr_sel_q] = act_ptr + 16'h0001;
    end
    if (rst_ext) begin
      sys_ctrl_d    = `SSP_SYS_CTRL_RST;
      status_word_d = `SSP_STATUS_WORD_RST;
      ptr_sel_d     = '0;
      pwr2_d        = `SSP_PWR2_RST;
      ana_en_d      = `SSP_ANA_EN_RST;
      for (int i = 0; i < NUM_PTRS; i++) begin
        dp_d[i] = 16'h0000;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      sys_ctrl_q    <= `SSP_SYS_CTRL_RST;
      status_word_q <= `SSP_STATUS_WORD_RST;
      ptr_sel_q     <= '0;
      pwr2_q        <= `SSP_PWR2_RST;
      ana_en_q      <= `SSP_ANA_EN_RST;
      for (int i = 0; i < NUM_PTRS; i++) begin
        dp_q[i] <= 16'h0000;
      end
    end else if (ce) begin
      sys_ctrl_q    <= sys_ctrl_d;
      status_word_q <= status_word_d;
      ptr_sel_q     <= ptr_sel_d;
      pwr2_q        <= pwr2_d;
      ana_en_q      <= ana_en_d;
      for (int i = 0; i < NUM_PTRS; i++) begin
        dp_q[i] <= dp_d[i];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Response and select outputs
  // ----------------------------------------------------------------------
  always_comb begin
    rdata_d  = 8'h00;
    if (op_rd) begin
      rdata_d = op_byte ? cur_val : {7'h00, cur_val[bit_addr[2:0]]};
    end
    rvalid_d = op_rd && !is_iram && !rst_ext;
    hit_d    = (op_rd | op_wr) && (sel != ssp_pkg::SR_NONE) && !rst_ext;
    std_d    = (op_rd | op_wr) && !is_iram && !rst_ext &&
               !sys_ctrl_q[`SSP_MAP_SEL_BIT];
    map_d    = (op_rd | op_wr) && !is_iram && !rst_ext &&
               sys_ctrl_q[`SSP_MAP_SEL_BIT];
    iram_d   = (op_rd | op_wr) && is_iram && !rst_ext;
    dptr_d   = dp_d[ptr_sel_d];
    can_d    = ext_acc && !rst_ext &&
               (act_ptr[15:8] == `SSP_EXT_CAN_PAGE);
    ext_d    = ext_acc && !rst_ext &&
               (act_ptr[15:8] != `SSP_EXT_CAN_PAGE);
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
      hit_q    <= 1'b0;
      std_q    <= 1'b0;
      map_q    <= 1'b0;
      iram_q   <= 1'b0;
      can_q    <= 1'b0;
      ext_q    <= 1'b0;
      dptr_q   <= 16'h0000;
      rst_q    <= 1'b1;
    end else if (ce) begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
      hit_q    <= hit_d;
      std_q    <= std_d;
      map_q    <= map_d;
      iram_q   <= iram_d;
      can_q    <= can_d;
      ext_q    <= ext_d;
      dptr_q   <= dptr_d;
      rst_q    <= rst_ext;
    end
  end

  assign rdata       = rdata_q;
  assign rvalid      = rvalid_q;
  assign hit         = hit_q;
  assign std_area    = std_q;
  assign map_area    = map_q;
  assign iram_sel    = iram_q;
  assign can_sel     = can_q;
  assign ext_sel     = ext_q;
  assign dptr        = dptr_q;
  assign map_sel     = sys_ctrl_q[`SSP_MAP_SEL_BIT];
  assign status_word = status_word_q;
  assign pwr2        = pwr2_q;
  assign ana_en      = ana_en_q;
  assign core_rst    = rst_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  logic wr_sys;
  assign wr_sys = op_wr && (sel == ssp_pkg::SR_SYS_CTRL);

  sequence s_pin_held;
    (ce && ext_reset) ##1 (ce && ext_reset) ##1 ce;
  endsequence
  property p_pin_sync;
    s_pin_held |=> core_rst;
  endproperty
  a_pin_sync: assert property (p_pin_sync)
    else $error("reset pin did not reach core reset");

  property p_status_rst;
    ce && rst_ext |=> status_word == 8'h00;
  endproperty
  a_status_rst: assert property (p_status_rst)
    else $error("status word not cleared on reset");

  property p_sys_rst;
    ce && rst_ext |=> sys_ctrl_q == `SSP_SYS_CTRL_RST && !map_sel;
  endproperty
  a_sys_rst: assert property (p_sys_rst)
    else $error("system control reset pattern wrong");

  property p_map_hold;
    ce && !rst_ext && !wr_sys |=> $stable(map_sel);
  endproperty
  a_map_hold: assert property (p_map_hold)
    else $error("map select changed without a write");

  property p_map_route;
    ce && !rst_ext && acc_rd && !acc_indirect && acc_addr[7] && map_sel
      |=> map_area && !std_area;
  endproperty
  a_map_route: assert property (p_map_route)
    else $error("mapped access not routed to mapped area");

  property p_std_route;
    ce && !rst_ext && acc_rd && !acc_indirect && acc_addr[7] && !map_sel
      |=> std_area && !map_area;
  endproperty
  a_std_route: assert property (p_std_route)
    else $error("access not routed to standard area");

  property p_ver_hidden;
    ce && !rst_ext && acc_rd && !acc_indirect && !map_sel &&
      acc_addr == `SSP_ADDR_VER_A |=> !hit;
  endproperty
  a_ver_hidden: assert property (p_ver_hidden)
    else $error("mapped register visible in standard area");

  property p_ptr_inc;
    ce && !rst_ext && dp_inc && !dp_load && !op_wr
      |=> dptr == $past(dptr) + 16'h0001;
  endproperty
  a_ptr_inc: assert property (p_ptr_inc)
    else $error("active pointer did not increment");

  property p_ptr_sel;
    ce && !rst_ext && acc_wr && !acc_indirect && !map_sel &&
      acc_addr == `SSP_ADDR_PTR_SEL && !dp_load && !dp_inc
      |=> ptr_sel_q == $past(acc_wdata[2:0]) &&
          dptr == dp_q[$past(acc_wdata[2:0])];
  endproperty
  a_ptr_sel: assert property (p_ptr_sel)
    else $error("pointer select did not pick the pointer");

  property p_can_page;
    ce && !rst_ext && ext_acc && dptr[15:8] == `SSP_EXT_CAN_PAGE
      |=> can_sel && !ext_sel;
  endproperty
  a_can_page: assert property (p_can_page)
    else $error("bus controller page not decoded");

  property p_bit_wr;
    ce && !rst_ext && !op_byte && bit_wr && bit_addr[7:3] == 5'h1A &&
      !map_sel
      |=> status_word[$past(bit_addr[2:0])] == $past(bit_wval);
  endproperty
  a_bit_wr: assert property (p_bit_wr)
    else $error("bit write to status word lost");

  property p_iram;
    ce && !rst_ext && acc_indirect && (acc_rd || acc_wr)
      |=> iram_sel && !hit;
  endproperty
  a_iram: assert property (p_iram)
    else $error("indirect access not sent to internal memory");

endmodule : ssp_top

// ==== tb/tb_ssp_top.sv ====
// Self-checking bench for the register space and data pointer bank
`timescale 1ns/100ps
module tb_ssp_top;
  // ----------------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------------
  logic        clock, resetn, ce, ext_reset, acc_indirect, acc_rd, acc_wr;
  logic        bit_rd, bit_wr, bit_wval, dp_inc, dp_load, ext_acc;
  logic [7:0]  acc_addr, acc_wdata, bit_addr;
  logic [15:0] dp_load_val;
  wire logic [7:0]  rdata, status_word, pwr2, ana_en;
  wire logic        rvalid, hit, std_area, map_area, iram_sel;
  wire logic        can_sel, ext_sel, map_sel, core_rst;
  wire logic [15:0] dptr;
  int          bad_count = 0;
  int          compares  = 0;
  int          cycles    = 0;

  ssp_top ssp_top_inst (
    .clock(clock), .resetn(resetn), .ce(ce), .ext_reset(ext_reset),
    .acc_addr(acc_addr), .acc_indirect(acc_indirect), .acc_rd(acc_rd),
    .acc_wr(acc_wr), .acc_wdata(acc_wdata), .bit_addr(bit_addr),
    .bit_rd(bit_rd), .bit_wr(bit_wr), .bit_wval(bit_wval),
    .dp_inc(dp_inc), .dp_load(dp_load), .dp_load_val(dp_load_val),
    .ext_acc(ext_acc), .rdata(rdata), .rvalid(rvalid), .hit(hit),
    .std_area(std_area), .map_area(map_area), .iram_sel(iram_sel),
    .can_sel(can_sel), .ext_sel(ext_sel), .dptr(dptr), .map_sel(map_sel),
    .status_word(status_word), .pwr2(pwr2), .ana_en(ana_en),
    .core_rst(core_rst)
  );

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic finish_test;
    $display("Checks made %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [15:0] exp,
                     input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic step;
    @(posedge clock);
    #1;
  endtask : step

  // Sets every strobe at once so none is assigned twice in one step
  task automatic strobes(input logic ar, input logic aw, input logic br,
                         input logic bw, input logic inc, input logic ld,
                         input logic ea);
    acc_rd  = ar;
    acc_wr  = aw;
    bit_rd  = br;
    bit_wr  = bw;
    dp_inc  = inc;
    dp_load = ld;
    ext_acc = ea;
  endtask : strobes

  task automatic idle;
    strobes(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    step();
  endtask : idle

  task automatic acc(input logic wr, input logic [7:0] a,
                     input logic [7:0] d);
    acc_addr  = a;
    acc_wdata = d;
    strobes(~wr, wr, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    step();
  endtask : acc

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp,
                        input logic exp_hit);
    acc(1'b0, a, 8'h00);
    chk("rvalid", 16'(1'b1), 16'(rvalid));
    chk("hit", 16'(exp_hit), 16'(hit));
    chk("rdata", 16'(exp), 16'(rdata));
  endtask : rd_chk

  task automatic bit_op(input logic wr, input logic [7:0] a,
                        input logic v);
    bit_addr = a;
    bit_wval = v;
    strobes(1'b0, 1'b0, ~wr, wr, 1'b0, 1'b0, 1'b0);
    step();
  endtask : bit_op

  task automatic dp_op(input logic ld, input logic [15:0] v);
    dp_load_val = v;
    strobes(1'b0, 1'b0, 1'b0, 1'b0, ~ld, ld, 1'b0);
    step();
  endtask : dp_op

  task automatic ext_chk(input logic [15:0] v, input logic exp_can);
    dp_op(1'b1, v);
    strobes(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    step();
    chk("can_sel", 16'(exp_can), 16'(can_sel));
    chk("ext_sel", 16'(!exp_can), 16'(ext_sel));
  endtask : ext_chk

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset_vals;
    rd_chk(8'hD0, 8'h00, 1'b1);
    chk("std_area", 16'h0001, 16'(std_area));
    rd_chk(8'hB1, 8'h21, 1'b1);
    chk("ana_en", 16'h00FF, 16'(ana_en));
    chk("pwr2", 16'h0000, 16'(pwr2));
    chk("map_sel", 16'h0000, 16'(map_sel));
    acc(1'b1, 8'hD0, 8'hA5);
    rd_chk(8'hD0, 8'hA5, 1'b1);
    rd_chk(8'hC3, 8'h00, 1'b0);
  endtask : t_reset_vals

  task automatic t_map_area;
    acc(1'b1, 8'hB1, 8'h10);
    chk("map_sel", 16'h0001, 16'(map_sel));
    rd_chk(8'h88, 8'h00, 1'b1);
    chk("map_area", 16'h0001, 16'(map_area));
    rd_chk(8'h90, 8'hFF, 1'b1);
    rd_chk(8'hFC, 8'h5A, 1'b1);
    rd_chk(8'hFD, 8'h3C, 1'b1);
    acc(1'b1, 8'hFE, 8'hEE);
    rd_chk(8'hFE, 8'h01, 1'b1);
    acc(1'b1, 8'h88, 8'h3C);
    chk("pwr2", 16'h003C, 16'(pwr2));
    rd_chk(8'hD0, 8'h00, 1'b0);
    idle();
    chk("map_sel", 16'h0001, 16'(map_sel));
    acc(1'b1, 8'hB1, 8'h00);
    chk("map_sel", 16'h0000, 16'(map_sel));
    rd_chk(8'h88, 8'h00, 1'b0);
    chk("std_area", 16'h0001, 16'(std_area));
    rd_chk(8'hD0, 8'hA5, 1'b1);
    rd_chk(8'hFC, 8'h00, 1'b0);
  endtask : t_map_area

  task automatic t_bits;
    acc(1'b1, 8'hD0, 8'h00);
    bit_op(1'b1, 8'hD3, 1'b1);
    chk("status_word", 16'h0008, 16'(status_word));
    bit_op(1'b0, 8'hD3, 1'b0);
    chk("bit rdata", 16'h0001, 16'(rdata));
    bit_op(1'b1, 8'hD7, 1'b1);
    chk("status_word", 16'h0088, 16'(status_word));
  endtask : t_bits

  task automatic t_pointers;
    logic [15:0] pv;
    for (int i = 0; i < 8; i++) begin
      acc(1'b1, 8'h92, 8'(i));
      dp_op(1'b1, {4'(i), 4'hA, 4'(7 - i), 4'h5});
    end
    for (int i = 0; i < 8; i++) begin
      pv = {4'(i), 4'hA, 4'(7 - i), 4'h5};
      acc(1'b1, 8'h92, 8'(i));
      rd_chk(8'h82, pv[7:0], 1'b1);
      rd_chk(8'h83, pv[15:8], 1'b1);
      rd_chk(8'h92, 8'(i), 1'b1);
      chk("dptr", pv, dptr);
    end
    dp_op(1'b1, 16'h00FF);
    dp_op(1'b0, 16'h0000);
    idle();
    chk("dptr", 16'h0100, dptr);
    acc(1'b1, 8'h83, 8'hF7);
    idle();
    chk("dptr", 16'hF700, dptr);
    acc(1'b1, 8'h92, 8'h00);
    idle();
    chk("dptr", 16'h0A75, dptr);
  endtask : t_pointers

  task automatic t_ext;
    ext_chk(16'hF700, 1'b1);
    ext_chk(16'hF7FF, 1'b1);
    ext_chk(16'hF6FF, 1'b0);
    ext_chk(16'hF800, 1'b0);
    ext_chk(16'hFFFF, 1'b0);
  endtask : t_ext

  task automatic t_iram;
    acc_indirect = 1'b1;
    acc(1'b0, 8'hD0, 8'h00);
    acc_indirect = 1'b0;
    chk("iram_sel", 16'h0001, 16'(iram_sel));
    chk("hit", 16'h0000, 16'(hit));
    chk("rvalid", 16'h0000, 16'(rvalid));
    acc(1'b0, 8'h30, 8'h00);
    chk("iram_sel", 16'h0001, 16'(iram_sel));
    chk("std_area", 16'h0000, 16'(std_area));
  endtask : t_iram

  task automatic t_ext_reset;
    ce = 1'b0;
    acc(1'b1, 8'hB1, 8'h10);
    chk("map_sel", 16'h0000, 16'(map_sel));
    ce = 1'b1;
    acc(1'b1, 8'hD0, 8'h5A);
    ext_reset = 1'b1;
    idle();
    chk("core_rst", 16'h0000, 16'(core_rst));
    repeat (3) step();
    chk("core_rst", 16'h0001, 16'(core_rst));
    chk("status_word", 16'h0000, 16'(status_word));
    chk("dptr", 16'h0000, dptr);
    ext_reset = 1'b0;
    repeat (4) step();
    chk("core_rst", 16'h0000, 16'(core_rst));
    rd_chk(8'hB1, 8'h21, 1'b1);
  endtask : t_ext_reset

  // ----------------------------------------------------------------------
  // Main sequence and timeout
  // ----------------------------------------------------------------------
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      $display("[ERR] timeout expected 0 seen %0d", cycles);
      finish_test();
    end
  end

  initial begin
    resetn = 1'b0; ce = 1'b1; ext_reset = 1'b0; acc_indirect = 1'b0;
    acc_rd = 1'b0; acc_wr = 1'b0; acc_addr = 8'h00; acc_wdata = 8'h00;
    bit_rd = 1'b0; bit_wr = 1'b0; bit_wval = 1'b0; bit_addr = 8'h00;
    dp_inc = 1'b0; dp_load = 1'b0; dp_load_val = 16'h0000;
    ext_acc = 1'b0;
    repeat (20) step();
    resetn = 1'b1;
    repeat (3) step();
    t_reset_vals();
    t_map_area();
    t_bits();
    t_pointers();
    t_ext();
    t_iram();
    t_ext_reset();
    finish_test();
  end
endmodule : tb_ssp_top
